// file: dv/mdio_mgmt_slave_asserts.sv
`timescale 1ns/1ps
module mdio_mgmt_slave_asserts
	import mgmt_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic nrst_i, // Synchronous reset, active low
	input wire logic mdc_i, // Management clock
	input wire logic mdio_i, // Resolved data wire
	input wire logic mdio_o, // Data drive level
	input wire logic mdio_oe_o, // Data drive enable
	input wire logic [4:0] station_address_straps_i, // Address straps
	input wire mgmt_pkg::event_vec_t event_i, // Event pulses
	input wire logic mgmt_irq_n_o, // Interrupt drive level
	input wire logic mgmt_irq_n_oe_o // Interrupt drive enable
);
	// ----------------------------------------------------------------
	// Age of the last management clock rise, saturating
	// ----------------------------------------------------------------
	logic mdc_q;
	logic mdc_d;
	logic [3:0] age_q;
	logic [3:0] age_d;

	always_comb begin
		mdc_d = mdc_i;
		age_d = age_q;
		if (mdc_i && !mdc_q) begin
			age_d = 4'h0;
		end else if (age_q != 4'hf) begin
			age_d = age_q + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		mdc_q <= nrst_i ? mdc_d : 1'b0;
		age_q <= nrst_i ? age_d : 4'hf;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	irq_level_a: assert property (mgmt_irq_n_o == 1'b0)
		else $error("interrupt level not low");
	reset_idle_a: assert property ($rose(nrst_i) |-> !mdio_oe_o && !mgmt_irq_n_oe_o)
		else $error("outputs driven at reset release");
	drive_time_a: assert property (($changed(mdio_oe_o) || (mdio_oe_o && $changed(mdio_o))) |-> age_q inside {[1:6]})
		else $error("data drive changed away from clock rise");
	ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o ##1 (mdio_oe_o && !mdio_o)[*6])
		else $error("turnaround not driven low");
	data_span_a: assert property ($rose(mdio_oe_o) |-> ##120 mdio_oe_o ##[1:30] !mdio_oe_o)
		else $error("read drive span wrong");
	irq_cause_a: assert property ($rose(mgmt_irq_n_oe_o) |-> $past(event_i, 2) != '0 || age_q < 4'h8)
		else $error("interrupt without cause");
	irq_clear_a: assert property ($fell(mgmt_irq_n_oe_o) |-> age_q inside {[2:8]})
		else $error("interrupt released without access");
	irq_hold_a: assert property (mgmt_irq_n_oe_o && age_q > 4'h8 |=> mgmt_irq_n_oe_o)
		else $error("interrupt dropped while idle");
	idle_free_a: assert property (age_q > 4'h9 |-> !mdio_oe_o)
		else $error("data wire driven while idle");
endmodule

bind mdio_mgmt_slave mdio_mgmt_slave_asserts mdio_mgmt_slave_asserts_inst (
	.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i),
	.mdc_i(mdc_i),
	.mdio_i(mdio_i),
	.mdio_o(mdio_o),
	.mdio_oe_o(mdio_oe_o),
	.station_address_straps_i(station_address_straps_i),
	.event_i(event_i),
	.mgmt_irq_n_o(mgmt_irq_n_o),
	.mgmt_irq_n_oe_o(mgmt_irq_n_oe_o)
);

// file: dv/mgmt_host_model.sv
`timescale 1ns/1ps
module mgmt_host_model (
	input wire logic sys_clk_i, // System clock
	input wire logic mdio_i, // Resolved data wire
	output logic mdc_o, // Management clock
	output logic mdio_o, // Host drive level
	output logic mdio_oe_o // Host drive enable
);
	// Clock stands still low between frames; released wire falls to the pull-up
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end

	task automatic clk_bit(input logic drv, input logic d, output logic s);
		mdio_oe_o <= drv;
		mdio_o <= d;
		repeat (4) @(posedge sys_clk_i);
		s = mdio_i;
		mdc_o <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		mdc_o <= 1'b0;
	endtask

	// Header is start, opcode, station and register address, sent MSB first
	task automatic xfer(input logic pre, input logic [13:0] hdr, input logic [15:0] wd,
		output logic [15:0] rd, output logic [1:0] ta);
		logic s;
		logic wr;
		wr = (hdr[11:10] != 2'b10);
		for (int i = 0; i < 32; i++) begin
			if (pre) begin
				clk_bit(1'b1, 1'b1, s);
			end
		end
		for (int i = 13; i >= 0; i--) begin
			clk_bit(1'b1, hdr[i], s);
		end
		clk_bit(wr, 1'b1, ta[1]);
		clk_bit(wr, 1'b0, ta[0]);
		for (int i = 15; i >= 0; i--) begin
			clk_bit(wr, wd[i], rd[i]);
		end
		mdio_oe_o <= 1'b0;
		// Let one edge pass so a following frame never re-drives the enable in this time step
		@(posedge sys_clk_i);
	endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	import mgmt_pkg::*;
	localparam logic [4:0] own_addr = 5'h05;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [4:0] straps = own_addr;
	event_vec_t ev = '0;
	logic mdc, host_d, host_oe, mdio_o, mdio_oe_o, irq_n, irq_oe;
	logic oe_seen = 1'b0;
	mgmt_word_t rd;
	logic [1:0] ta;
	int n_errors = 0;
	int checks = 0;
	// Pull-up wins only when nobody drives
	wire mdio_w = mdio_oe_o ? mdio_o : (host_oe ? host_d : 1'b1);

	always #25 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (mdio_oe_o) begin
			oe_seen <= 1'b1;
		end
	end

	mdio_mgmt_slave mdio_mgmt_slave_inst (
		.sys_clk_i(sys_clk_i), // Clock
		.nrst_i(nrst_i), // Reset
		.mdc_i(mdc), // Management clock
		.mdio_i(mdio_w), // Wire
		.mdio_o(mdio_o), // Drive level
		.mdio_oe_o(mdio_oe_o), // Drive enable
		.station_address_straps_i(straps), // Straps
		.event_i(ev), // Events
		.mgmt_irq_n_o(irq_n), // Irq level
		.mgmt_irq_n_oe_o(irq_oe) // Irq enable
	);
	mgmt_host_model mgmt_host_model_inst (
		.sys_clk_i(sys_clk_i), // Clock
		.mdio_i(mdio_w), // Wire
		.mdc_o(mdc), // Management clock
		.mdio_o(host_d), // Host level
		.mdio_oe_o(host_oe) // Host enable
	);

	task automatic rd_reg(input logic pre, input logic [4:0] phy, input logic [4:0] rg);
		mgmt_host_model_inst.xfer(pre, {2'b01, 2'b10, phy, rg}, 16'h0000, rd, ta);
	endtask
	task automatic wr_reg(input logic [4:0] phy, input logic [4:0] rg, input mgmt_word_t wd);
		mgmt_host_model_inst.xfer(1'b0, {2'b01, 2'b01, phy, rg}, wd, rd, ta);
	endtask
	task automatic clr_seen;
		@(posedge sys_clk_i);
		oe_seen <= 1'b0;
	endtask

	task automatic t_reset_regs;
		rd_reg(1'b1, own_addr, 5'h18);
		`CHK("turnaround", 2'b10, ta)
		`CHK("mask reset", 16'h0000, rd)
		rd_reg(1'b0, own_addr, 5'h19);
		`CHK("flags reset", 16'h0000, rd)
		rd_reg(1'b0, own_addr, 5'h03);
		`CHK("unmapped", 16'h0000, rd)
	endtask
	task automatic t_mask_rw;
		wr_reg(own_addr, 5'h18, 16'ha5c3);
		rd_reg(1'b1, own_addr, 5'h18);
		`CHK("mask rw", 16'ha5c3, rd)
	endtask
	task automatic t_foreign;
		clr_seen();
		wr_reg(5'h1a, 5'h18, 16'h0000);
		rd_reg(1'b0, 5'h1a, 5'h18);
		`CHK("foreign read", 16'hffff, rd)
		`CHK("foreign drive", 1'b0, oe_seen)
		rd_reg(1'b0, own_addr, 5'h18);
		`CHK("mask kept", 16'ha5c3, rd)
	endtask
	task automatic t_clause45;
		clr_seen();
		mgmt_host_model_inst.xfer(1'b0, {2'b00, 2'b10, own_addr, 5'h18}, 16'h0000, rd, ta);
		mgmt_host_model_inst.xfer(1'b0, {2'b00, 2'b01, own_addr, 5'h18}, 16'h0001, rd, ta);
		// Undefined opcode to our own address must be counted out like a foreign frame
		mgmt_host_model_inst.xfer(1'b0, {2'b01, 2'b11, own_addr, 5'h18}, 16'h0001, rd, ta);
		`CHK("st00 drive", 1'b0, oe_seen)
		rd_reg(1'b0, own_addr, 5'h18);
		`CHK("st00 write", 16'ha5c3, rd)
	endtask
	task automatic pulse(input event_vec_t e);
		@(posedge sys_clk_i);
		ev <= e;
		@(posedge sys_clk_i);
		ev <= '0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	// Each source alone in the mask, a neighbour fires masked beside it
	task automatic t_events;
		event_vec_t e;
		for (int i = 0; i < 9; i++) begin
			e = (9'h001 << i) | (9'h001 << ((i + 1) % 9));
			wr_reg(own_addr, 5'h18, 16'h0001 << i);
			pulse(e);
			`CHK("irq on", 1'b1, irq_oe)
			`CHK("irq level", 1'b0, irq_n)
			rd_reg(1'b0, own_addr, 5'h19);
			`CHK("flags", {7'h00, e}, rd)
			`CHK("irq off", 1'b0, irq_oe)
			rd_reg(1'b0, own_addr, 5'h19);
			`CHK("flags cleared", 16'h0000, rd)
		end
		wr_reg(own_addr, 5'h18, 16'h0000);
		pulse(9'h008);
		`CHK("irq masked", 1'b0, irq_oe)
		rd_reg(1'b0, own_addr, 5'h19);
		`CHK("masked flag", 16'h0008, rd)
	endtask

	task automatic conclude;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		// Straps move after release; the latched address must not follow
		straps <= 5'h1a;
		repeat (4) @(posedge sys_clk_i);
		t_reset_regs();
		t_mask_rw();
		t_foreign();
		t_clause45();
		t_events();
		conclude();
	end

	initial begin
		#3000000;
		n_errors++;
		conclude();
	end
endmodule

// file: logic/bit_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser; first stage feeds only the second
// ----------------------------------------------------------------
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i, // System clock
	input wire logic [WIDTH-1:0] async_i, // Asynchronous level
	output logic [WIDTH-1:0] sync_o // Synchronised level
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// No reset so straps are already valid while reset is held
	always_ff @(posedge sys_clk_i) begin
		meta_q <= async_i;
		sync_q <= meta_q;
	end

	assign sync_o = sync_q;
endmodule

// file: logic/irq_event_unit.sv
`timescale 1ns/1ps
`include "mgmt_defines.svh"
module irq_event_unit (
	input wire logic sys_clk_i, // System clock
	input wire logic nrst_i, // Synchronous reset, active low
	input wire mgmt_pkg::event_vec_t event_i, // One-cycle event pulses
	input wire logic mask_we_i, // Write strobe for mask
	input wire mgmt_pkg::mgmt_word_t mask_wdata_i, // Mask write data
	input wire logic flags_clr_i, // Read of flags register clears it
	output mgmt_pkg::mgmt_word_t mask_o, // Mask register
	output mgmt_pkg::mgmt_word_t flags_o, // Flags register
	output logic pending_o // Unmasked event pending
);
	import mgmt_pkg::*;

	mgmt_word_t mask_q, mask_d;
	event_vec_t flags_q, flags_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		mask_d = mask_q;
		if (mask_we_i) begin
			mask_d = mask_wdata_i;
		end
		// Set wins over clear so an event in the clearing cycle survives
		flags_d = (flags_clr_i ? `FLAGS_RESET : flags_q) | event_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			mask_q <= `MASK_RESET;
			flags_q <= `FLAGS_RESET;
		end else begin
			mask_q <= mask_d;
			flags_q <= flags_d;
		end
	end

	assign mask_o = mask_q;
	assign flags_o = {{(`MGMT_DATA_W-`MGMT_EVENT_N){1'b0}}, flags_q};
	assign pending_o = |(flags_q & mask_q[`MGMT_EVENT_N-1:0]);
endmodule

// file: logic/mdio_mgmt_slave.sv
`timescale 1ns/1ps
`include "mgmt_defines.svh"

// Overview of operation
// - Frames without preamble are accepted
// - Start pattern zero then one opens frame
// - Start zero zero: ignore frame, never drive
// - Opcode 10 reads, 01 writes
// - Five-bit station address, MSB first
// - Answer only when station address matches
// - Five-bit register address, MSB first
// - Read turnaround: release, then drive zero
// - Sixteen data bits, MSB first
// - Idle line undriven, pulled high
// - Bits sampled and driven on management clock
// - Interrupt pin active low, open drain
// - Nine event sources raise interrupts
// - Mask register 24 enables each event
// - Event sets bit in register 25
// - Reading register 25 clears all bits except an event arriving in the clearing cycle
module mdio_mgmt_slave (
	input wire logic sys_clk_i, // System clock, 20 MHz
	input wire logic nrst_i, // Synchronous reset, active low
	input wire logic mdc_i, // Management clock from host
	input wire logic mdio_i, // Management data line level
	output logic mdio_o, // Management data drive level
	output logic mdio_oe_o, // Management data drive enable
	input wire logic [4:0] station_address_straps_i, // Address straps
	input wire mgmt_pkg::event_vec_t event_i, // Event pulses, sys_clk domain
	output logic mgmt_irq_n_o, // Interrupt drive level, always low
	output logic mgmt_irq_n_oe_o // Interrupt drive enable, high when asserted
);
	import mgmt_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] link_sync;
	logic [4:0] straps_sync;
	logic mdc_s;
	logic mdio_s;

	bit_sync #(
		.WIDTH(2)
	) u_link_sync (
		.sys_clk_i(sys_clk_i),
		.async_i({mdc_i, mdio_i}),
		.sync_o(link_sync)
	);

	bit_sync #(
		.WIDTH(`MGMT_ADDR_W)
	) u_strap_sync (
		.sys_clk_i(sys_clk_i),
		.async_i(station_address_straps_i),
		.sync_o(straps_sync)
	);

	assign mdc_s = link_sync[1];
	assign mdio_s = link_sync[0];

	// ----------------------------------------------------------------
	// Station address capture
	// ----------------------------------------------------------------
	logic [4:0] station_addr_q, station_addr_d;

	// Tracks the straps while reset is held, frozen on release
	always_comb begin
		station_addr_d = station_addr_q;
		if (!nrst_i) begin
			station_addr_d = straps_sync;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		station_addr_q <= station_addr_d;
	end

	// ----------------------------------------------------------------
	// Management clock edge detect
	// ----------------------------------------------------------------
	logic mdc_prev_q, mdc_prev_d;
	logic mdc_rise;

	always_comb begin
		mdc_prev_d = mdc_s;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			mdc_prev_q <= 1'b0;
		end else begin
			mdc_prev_q <= mdc_prev_d;
		end
	end

	// A stopped clock gives no edges, so the frame simply pauses
	assign mdc_rise = mdc_s & ~mdc_prev_q;

	// ----------------------------------------------------------------
	// Interrupt unit
	// ----------------------------------------------------------------
	logic mask_we;
	mgmt_word_t mask_wdata;
	logic flags_clr;
	mgmt_word_t mask_val;
	mgmt_word_t flags_val;
	logic irq_pending;

	irq_event_unit u_irq (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.event_i(event_i),
		.mask_we_i(mask_we),
		.mask_wdata_i(mask_wdata),
		.flags_clr_i(flags_clr),
		.mask_o(mask_val),
		.flags_o(flags_val),
		.pending_o(irq_pending)
	);

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	frame_state_e state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic [11:0] hdr_sr_q, hdr_sr_d;
	mgmt_word_t data_sr_q, data_sr_d;
	logic is_read_q, is_read_d;
	logic [4:0] reg_addr_q, reg_addr_d;
	pin_drive_s drive_q, drive_d;
	frame_hdr_s hdr_now;
	logic addr_match;
	mgmt_word_t read_word;

	// Header including the bit sampled at this edge
	assign hdr_now = frame_hdr_s'({hdr_sr_q[10:0], mdio_s});
	assign addr_match = (hdr_now.phy_addr == station_addr_q);

	// Register read mux; registers outside the interrupt pair read zero
	always_comb begin
		case (hdr_now.reg_addr)
			`REG_IRQ_ENABLE_MASK: read_word = mask_val;
			`REG_IRQ_EVENT_FLAGS: read_word = flags_val;
			default: read_word = '0;
		endcase
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		hdr_sr_d = hdr_sr_q;
		data_sr_d = data_sr_q;
		is_read_d = is_read_q;
		reg_addr_d = reg_addr_q;
		drive_d = drive_q;
		mask_we = 1'b0;
		mask_wdata = '0;
		flags_clr = 1'b0;
		if (mdc_rise) begin
			case (state_q)
				FR_IDLE: begin
					// Preamble ones keep us here; first zero is the start bit
					drive_d.enable = 1'b0;
					if (mdio_s != `MGMT_IDLE_LEVEL) begin
						state_d = FR_START;
					end
				end
				FR_START: begin
					if (mdio_s == `MGMT_ST_SECOND) begin
						state_d = FR_HDR;
						cnt_d = `MGMT_HDR_LAST;
					end else begin
						state_d = FR_SKIP;
						cnt_d = `MGMT_SKIP_AFTER_ST;
					end
				end
				FR_HDR: begin
					hdr_sr_d = {hdr_sr_q[10:0], mdio_s};
					if (cnt_q == '0) begin
						reg_addr_d = hdr_now.reg_addr;
						if (addr_match && hdr_now.opcode == `MGMT_OP_READ) begin
							state_d = FR_TA;
							cnt_d = `MGMT_TA_LAST;
							is_read_d = 1'b1;
							data_sr_d = read_word;
							// Clear on the snapshot so the read word holds the events
							flags_clr = (hdr_now.reg_addr == `REG_IRQ_EVENT_FLAGS);
						end else if (addr_match && hdr_now.opcode == `MGMT_OP_WRITE) begin
							state_d = FR_TA;
							cnt_d = `MGMT_TA_LAST;
							is_read_d = 1'b0;
						end else begin
							// Other station or undefined opcode: stay off the line
							state_d = FR_SKIP;
							cnt_d = `MGMT_SKIP_AFTER_HDR;
						end
					end else begin
						cnt_d = cnt_q - 5'h01;
					end
				end
				FR_TA: begin
					// Host turnaround bits on writes are not checked
					if (cnt_q == '0) begin
						state_d = FR_DATA;
						cnt_d = `MGMT_DATA_LAST;
						if (is_read_q) begin
							drive_d.level = data_sr_q[`MGMT_DATA_W-1];
							data_sr_d = {data_sr_q[`MGMT_DATA_W-2:0], 1'b0};
						end
					end else begin
						cnt_d = cnt_q - 5'h01;
						if (is_read_q) begin
							drive_d.enable = 1'b1;
							drive_d.level = `MGMT_TA_DRIVE;
						end
					end
				end
				FR_DATA: begin
					if (cnt_q == '0) begin
						state_d = FR_IDLE;
						drive_d.enable = 1'b0;
						if (!is_read_q) begin
							mask_we = (reg_addr_q == `REG_IRQ_ENABLE_MASK);
							mask_wdata = {data_sr_q[`MGMT_DATA_W-2:0], mdio_s};
						end
					end else begin
						cnt_d = cnt_q - 5'h01;
						if (is_read_q) begin
							drive_d.level = data_sr_q[`MGMT_DATA_W-1];
							data_sr_d = {data_sr_q[`MGMT_DATA_W-2:0], 1'b0};
						end else begin
							data_sr_d = {data_sr_q[`MGMT_DATA_W-2:0], mdio_s};
						end
					end
				end
				FR_SKIP: begin
					// Count out the rest of a foreign frame without driving
					drive_d.enable = 1'b0;
					if (cnt_q == '0) begin
						state_d = FR_IDLE;
					end else begin
						cnt_d = cnt_q - 5'h01;
					end
				end
				default: begin
					state_d = FR_IDLE;
					drive_d.enable = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state_q <= FR_IDLE;
			cnt_q <= '0;
			hdr_sr_q <= '0;
			data_sr_q <= '0;
			is_read_q <= 1'b0;
			reg_addr_q <= '0;
			drive_q <= '{level: 1'b1, enable: 1'b0};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			hdr_sr_q <= hdr_sr_d;
			data_sr_q <= data_sr_d;
			is_read_q <= is_read_d;
			reg_addr_q <= reg_addr_d;
			drive_q <= drive_d;
		end
	end

	assign mdio_o = drive_q.level;
	assign mdio_oe_o = drive_q.enable;

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	logic irq_oe_q, irq_oe_d;
	logic irq_lvl_q, irq_lvl_d;

	// Open drain: only ever pull low, so several devices can share the wire
	always_comb begin
		irq_oe_d = irq_pending;
		irq_lvl_d = 1'b0;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			irq_oe_q <= 1'b0;
			irq_lvl_q <= 1'b0;
		end else begin
			irq_oe_q <= irq_oe_d;
			irq_lvl_q <= irq_lvl_d;
		end
	end

	assign mgmt_irq_n_o = irq_lvl_q;
	assign mgmt_irq_n_oe_o = irq_oe_q;
endmodule

// file: logic/mgmt_defines.svh
`ifndef MGMT_DEFINES_SVH
`define MGMT_DEFINES_SVH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define MGMT_ADDR_W 5
`define MGMT_DATA_W 16
`define MGMT_HDR_W 12
`define MGMT_CNT_W 5
`define MGMT_EVENT_N 9

// ----------------------------------------------------------------
// Frame codes and bit counts (counts are loaded as value minus one)
// ----------------------------------------------------------------
`define MGMT_ST_SECOND 1'b1
`define MGMT_IDLE_LEVEL 1'b1
`define MGMT_OP_READ 2'b10
`define MGMT_OP_WRITE 2'b01
`define MGMT_HDR_LAST 5'h0b
`define MGMT_TA_LAST 5'h01
`define MGMT_DATA_LAST 5'h0f
`define MGMT_SKIP_AFTER_ST 5'h1d
`define MGMT_SKIP_AFTER_HDR 5'h11
`define MGMT_TA_DRIVE 1'b0

// ----------------------------------------------------------------
// Register numbers and reset values
// ----------------------------------------------------------------
`define REG_IRQ_ENABLE_MASK 5'h18
`define REG_IRQ_EVENT_FLAGS 5'h19
`define MASK_RESET 16'h0000
`define FLAGS_RESET 9'h000
`define STATION_ADDR_DEFAULT 5'h01

// ----------------------------------------------------------------
// Event bit positions in mask and flags registers
// ----------------------------------------------------------------
`define EV_NEG_STATUS 0
`define EV_NEG_PAGE 1
`define EV_FIFO_FLOW 2
`define EV_LINK_CHANGE 3
`define EV_CRC_ERROR 4
`define EV_ERR_CNT_FULL 5
`define EV_RX_STATUS 6
`define EV_DOWNSHIFT 7
`define EV_SYNC_LOST 8

`endif

// file: logic/mgmt_pkg.sv
package mgmt_pkg;

	typedef enum logic [3:0] {
		FR_IDLE,
		FR_START,
		FR_HDR,
		FR_TA,
		FR_DATA,
		FR_SKIP
	} frame_state_e;

	// Decoded frame header: opcode, station and register address
	typedef struct packed {
		logic [1:0] opcode;
		logic [4:0] phy_addr;
		logic [4:0] reg_addr;
	} frame_hdr_s;

	// Drive of a two-way or open-drain pin
	typedef struct packed {
		logic level;
		logic enable;
	} pin_drive_s;

	typedef logic [8:0] event_vec_t;
	typedef logic [15:0] mgmt_word_t;

endpackage
